// ===== dv/adm_acq_checker.sv
`timescale 1ns/100ps
module adm_acq_checker
   import adm_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire adm_pkg::adm_mode_e mode_i,
   input wire logic [7:0] acq_count_i,
   input wire logic [6:0] record_points_i,
   input wire logic [31:0] tb_ns_per_div_i,
   input wire logic needs_interp_i,
   input wire logic ext_clk_en_i,
   input wire logic start_i,
   input wire logic point_valid_o,
   input wire logic [5:0] point_index_o,
   input wire logic seq_done_o,
   input wire logic busy_o,
   input wire adm_pkg::adm_mode_e eff_mode_o,
   input wire logic [3:0] res_bits_o,
   input wire logic scroll_inhibit_o
);
   logic fast_tb_w;
   logic [6:0] pts_w;
   // The 500 ns fallback is tied to the internal clock only.
   assign fast_tb_w = !ext_clk_en_i && (tb_ns_per_div_i < 32'h000001f4);
   assign pts_w = (record_points_i == 7'h00) ? 7'h01 : record_points_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence held_s;
      !$past(reset_i) && $stable(mode_i);
   endsequence
   sequence start_s;
      start_i && !busy_o && $stable(acq_count_i) && !$past(reset_i, 2);
   endsequence
   sequence abort_s;
      ##[1:3] !busy_o;
   endsequence
   reset_dflt_a: assert property ($fell(reset_i) |->
      eff_mode_o == ADM_SAMPLE && res_bits_o == 4'h8 && !busy_o) else $error("Defaults wrong after reset.");
   peak_fall_a: assert property (held_s ##0 (mode_i == ADM_PEAK) |->
      eff_mode_o == ((needs_interp_i || fast_tb_w) ? ADM_SAMPLE : ADM_PEAK)) else $error("Min-max fallback wrong.");
   hires_fall_a: assert property (held_s ##0 (mode_i == ADM_HIRES) |->
      eff_mode_o == (needs_interp_i ? ADM_SAMPLE : ADM_HIRES)) else $error("Average fallback wrong.");
   res_range_a: assert property (res_bits_o >= 4'h8 && res_bits_o <= 4'hf &&
      (eff_mode_o == ADM_HIRES || res_bits_o == 4'h8)) else $error("Resolution out of range.");
   scroll_gate_a: assert property (held_s |->
      scroll_inhibit_o == (mode_i == ADM_ENV || mode_i == ADM_AVG)) else $error("Scroll inhibit wrong.");
   start_busy_a: assert property (held_s ##0 start_s |=> busy_o [*3])
      else $error("Start not taken.");
   done_idle_a: assert property (seq_done_o |=> !seq_done_o && !busy_o)
      else $error("Done not followed by idle.");
   abort_clear_a: assert property (busy_o && ($changed(mode_i) || $changed(acq_count_i)) |->
      !seq_done_o throughout abort_s) else $error("Config change did not abort.");
   index_range_a: assert property (point_valid_o |-> {1'b0, point_index_o} < pts_w)
      else $error("Point index beyond record.");
endmodule : adm_acq_checker

bind adm_acq_decimator adm_acq_checker adm_acq_checker_inst (.clk_i(clk_i), .reset_i(reset_i),
   .mode_i(mode_i), .acq_count_i(acq_count_i), .record_points_i(record_points_i),
   .tb_ns_per_div_i(tb_ns_per_div_i), .needs_interp_i(needs_interp_i), .ext_clk_en_i(ext_clk_en_i),
   .start_i(start_i), .point_valid_o(point_valid_o), .point_index_o(point_index_o),
   .seq_done_o(seq_done_o), .busy_o(busy_o), .eff_mode_o(eff_mode_o), .res_bits_o(res_bits_o),
   .scroll_inhibit_o(scroll_inhibit_o));

// ===== dv/adm_digitizer_model.sv
`timescale 1ns/100ps
module adm_digitizer_model (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic run_i,
   input wire logic [7:0] salt_i,
   input wire logic point_valid_i,
   input wire logic [5:0] point_index_i,
   input wire logic [14:0] point_data_i,
   output logic sample_valid_o,
   output logic [7:0] sample_o
);
   logic [7:0] cnt_q;
   logic [7:0] noise_q;
   logic [14:0] rec_mem [0:63];
   // One sample per clock keeps the stream within the rate the clock setting allows.
   assign sample_valid_o = run_i;
   // Between frames the data keeps moving so a stale value never passes for a sample.
   assign sample_o = run_i ? salt_i + cnt_q * 8'h1d : noise_q;
   always_ff @(posedge clk_i) begin
      cnt_q <= (run_i && !reset_i) ? cnt_q + 8'h01 : 8'h00;
      noise_q <= reset_i ? 8'h5a : noise_q + 8'h3b;
      if (point_valid_i) begin
         rec_mem[point_index_i] <= point_data_i;
      end
   end
endmodule : adm_digitizer_model

// ===== dv/test_acquisition_decimation_modes.sv
`timescale 1ns/100ps
module test_acquisition_decimation_modes;
   import adm_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic clk_en_i = 1'b1;
   adm_mode_e mode_i = ADM_SAMPLE;
   logic [7:0] acq_count_i = 8'h01;
   logic [15:0] record_span_i = 16'h0008;
   logic [6:0] record_points_i = 7'h04;
   logic [31:0] tb_ns_per_div_i = 32'h000001f4;
   logic needs_interp_i = 1'b0;
   logic ext_clk_en_i = 1'b0;
   logic [31:0] external_clock_setting_i = 32'h05f5e100;
   logic start_i = 1'b0;
   logic trigger_i = 1'b0;
   logic run = 1'b0;
   logic [7:0] salt = 8'h00;
   logic sample_valid_i;
   logic [7:0] sample_i;
   logic point_valid_o;
   logic [5:0] point_index_o;
   logic [14:0] point_data_o;
   logic seq_done_o;
   logic busy_o;
   logic [7:0] acq_done_count_o;
   adm_mode_e eff_mode_o;
   logic [3:0] res_bits_o;
   logic scroll_inhibit_o;
   int bad_count = 0;
   int num_checks = 0;
   int done_cnt = 0;
   int cyc = 0;

   adm_acq_decimator adm_acq_decimator_inst (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
      .mode_i(mode_i), .acq_count_i(acq_count_i), .record_span_i(record_span_i),
      .record_points_i(record_points_i), .tb_ns_per_div_i(tb_ns_per_div_i), .needs_interp_i(needs_interp_i),
      .ext_clk_en_i(ext_clk_en_i), .external_clock_setting_i(external_clock_setting_i), .start_i(start_i),
      .trigger_i(trigger_i), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
      .point_valid_o(point_valid_o), .point_index_o(point_index_o), .point_data_o(point_data_o),
      .seq_done_o(seq_done_o), .busy_o(busy_o), .acq_done_count_o(acq_done_count_o),
      .eff_mode_o(eff_mode_o), .res_bits_o(res_bits_o), .scroll_inhibit_o(scroll_inhibit_o));
   adm_digitizer_model adm_digitizer_model_inst (.clk_i(clk_i), .reset_i(reset_i), .run_i(run),
      .salt_i(salt), .point_valid_i(point_valid_o), .point_index_i(point_index_o),
      .point_data_i(point_data_o), .sample_valid_o(sample_valid_i), .sample_o(sample_i));

   always #25 clk_i = ~clk_i;

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up

   // The ceiling is about twenty times the whole run, so only a hang reaches it.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         $display("[FAIL] %0t run timed out", $time);
         wrap_up();
      end
   end

   // Pulses are counted away from the edge that launches them.
   always @(negedge clk_i) begin
      if (seq_done_o === 1'b1) done_cnt++;
   end

   task automatic tick();
      @(posedge clk_i);
      #2;
   endtask : tick

   task automatic check(input logic [14:0] seen, input logic [14:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s: got %0h want %0h", $time, what, seen, exp);
      end
   endtask : check

   function automatic logic [14:0] expv(adm_mode_e m, int k, int iv, int na, logic [7:0] s0);
      logic [7:0] v;
      int mx = 0;
      int mn = 255;
      int sm = 0;
      int fs = 0;
      for (int a = 0; a < na; a++) begin
         for (int j = 0; j < iv; j++) begin
            v = s0 + 8'(a) * 8'h51 + 8'(k * iv + j) * 8'h1d;
            mx = (v > mx) ? v : mx;
            mn = (v < mn) ? v : mn;
            sm += v;
            if (j == 0) fs += v;
         end
      end
      case (m)
         ADM_PEAK, ADM_ENV: return 15'((k % 2) ? mn : mx);
         ADM_HIRES: return 15'(sm / iv);
         ADM_AVG: return 15'(fs / na);
         default: return 15'(fs);
      endcase
   endfunction : expv

   // A changed mode or count needs stable cycles before a start is taken.
   task automatic cfg(input adm_mode_e m, input logic [7:0] na, input logic [15:0] span, input logic [6:0] pts);
      mode_i = m;
      acq_count_i = na;
      record_span_i = span;
      record_points_i = pts;
      repeat (3) tick();
   endtask : cfg

   task automatic arm();
      start_i = 1'b1;
      tick();
      start_i = 1'b0;
      repeat (40) tick();
   endtask : arm

   task automatic acquire(input logic [7:0] s, input logic [15:0] n);
      trigger_i = 1'b1;
      tick();
      trigger_i = 1'b0;
      salt = s;
      run = 1'b1;
      repeat (n) tick();
      run = 1'b0;
      repeat (60) tick();
   endtask : acquire

   task automatic go(input adm_mode_e m, input logic [7:0] na, input logic [15:0] span, input logic [6:0] pts,
                     input logic [7:0] s0);
      int d0;
      logic [14:0] exp_pt;
      cfg(m, na, span, pts);
      d0 = done_cnt;
      arm();
      for (int a = 0; a < na; a++) acquire(s0 + 8'(a) * 8'h51, span);
      repeat (200) if (busy_o === 1'b1) tick();
      for (int k = 0; k < pts; k++) begin
         exp_pt = expv(m, k, span / pts, na, s0);
         check(adm_digitizer_model_inst.rec_mem[k], exp_pt, "point");
      end
      check(15'(done_cnt - d0), 15'h0001, "done");
      check(15'(acq_done_count_o), 15'(na), "acqs");
      check(15'(busy_o), 15'h0000, "busy");
   endtask : go

   task automatic t_modes();
      check(15'(eff_mode_o), 15'(ADM_SAMPLE), "default");
      go(ADM_SAMPLE, 8'h01, 16'h0008, 7'h04, 8'h10);
      go(ADM_PEAK, 8'h01, 16'h000c, 7'h04, 8'h33);
      needs_interp_i = 1'b1;
      tick();
      check(15'(eff_mode_o), 15'(ADM_SAMPLE), "interp");
      needs_interp_i = 1'b0;
      tb_ns_per_div_i = 32'h000001f3;
      tick();
      check(15'(eff_mode_o), 15'(ADM_SAMPLE), "fast");
      tb_ns_per_div_i = 32'h000001f4;
      tick();
      check(15'(eff_mode_o), 15'(ADM_PEAK), "kept");
      $display("single modes test done");
   endtask : t_modes

   task automatic t_hires();
      logic [31:0] tbv [4] = '{32'h000001f4, 32'h000007d0, 32'h00001f40, 32'h7fffffff};
      logic [3:0] rv [4] = '{4'h8, 4'h9, 4'ha, 4'hf};
      go(ADM_HIRES, 8'h01, 16'h0050, 7'h02, 8'h20);
      for (int i = 0; i < 4; i++) begin
         tb_ns_per_div_i = tbv[i];
         tick();
         check(15'(res_bits_o), 15'(rv[i]), "res");
      end
      ext_clk_en_i = 1'b1;
      tick();
      check(15'(res_bits_o), 15'h0008, "ext res");
      ext_clk_en_i = 1'b0;
      needs_interp_i = 1'b1;
      tick();
      check(15'(eff_mode_o), 15'(ADM_SAMPLE), "interp");
      needs_interp_i = 1'b0;
      tb_ns_per_div_i = 32'h000001f4;
      $display("interval average test done");
   endtask : t_hires

   task automatic t_multi();
      int d0;
      go(ADM_ENV, 8'h03, 16'h0008, 7'h04, 8'hc0);
      check(15'(scroll_inhibit_o), 15'h0001, "scroll");
      go(ADM_AVG, 8'h02, 16'h0050, 7'h02, 8'h44);
      cfg(ADM_ENV, 8'h02, 16'h0008, 7'h04);
      d0 = done_cnt;
      arm();
      acquire(8'hf7, 16'h0008);
      acq_count_i = 8'h03;
      repeat (4) tick();
      check(15'(busy_o), 15'h0000, "abort");
      check(15'(done_cnt - d0), 15'h0000, "abort done");
      // Leftover extremes from the aborted run would corrupt this record.
      go(ADM_ENV, 8'h02, 16'h0008, 7'h04, 8'h07);
      $display("multi acquisition test done");
   endtask : t_multi

   // A frozen block must ignore a trigger, so samples sent afterwards find it still armed.
   task automatic t_freeze();
      cfg(ADM_SAMPLE, 8'h01, 16'h0008, 7'h04);
      arm();
      clk_en_i = 1'b0;
      trigger_i = 1'b1;
      repeat (3) tick();
      trigger_i = 1'b0;
      clk_en_i = 1'b1;
      salt = 8'h3c;
      run = 1'b1;
      repeat (8) tick();
      run = 1'b0;
      repeat (4) tick();
      check(15'(busy_o), 15'h0001, "frozen trigger");
      acquire(8'h66, 16'h0008);
      check(adm_digitizer_model_inst.rec_mem[0], 15'h0066, "after freeze");
      check(15'(busy_o), 15'h0000, "freeze busy");
      $display("clock enable test done");
   endtask : t_freeze

   initial begin
      repeat (8) tick();
      reset_i = 1'b0;
      repeat (2) tick();
      t_modes();
      t_hires();
      t_multi();
      t_freeze();
      wrap_up();
   end
endmodule : test_acquisition_decimation_modes

// ===== verilog/adm_acq_decimator.sv
`timescale 1ns/100ps
`include "adm_params.svh"

module adm_acq_decimator (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire adm_pkg::adm_mode_e mode_i,
   input wire logic [7:0] acq_count_i,
   input wire logic [15:0] record_span_i,
   input wire logic [6:0] record_points_i,
   input wire logic [31:0] tb_ns_per_div_i,
   input wire logic needs_interp_i,
   input wire logic ext_clk_en_i,
   input wire logic [31:0] external_clock_setting_i,
   input wire logic start_i,
   input wire logic trigger_i,
   input wire logic sample_valid_i,
   input wire logic [7:0] sample_i,
   output logic point_valid_o,
   output logic [5:0] point_index_o,
   output logic [14:0] point_data_o,
   output logic seq_done_o,
   output logic busy_o,
   output logic [7:0] acq_done_count_o,
   output adm_pkg::adm_mode_e eff_mode_o,
   output logic [3:0] res_bits_o,
   output logic scroll_inhibit_o
);
   import adm_pkg::*;

   // Adds one bit per two whole doublings of num over den, capped at the useful range.
   function automatic logic [3:0] adm_res_bits(input logic [31:0] num, input logic [31:0] den);
      logic [4:0] k;
      k = 5'h00;
      for (int i = 1; i <= `ADM_RES_DOUBLINGS; i++) begin
         if ({16'h0000, num} >= ({16'h0000, den} << i)) begin
            k = 5'(i);
         end
      end
      adm_res_bits = `ADM_RES_BASE + 4'(k[4:1]);
   endfunction : adm_res_bits

   adm_state_e state_q;
   adm_mode_e mode_q;
   logic [7:0] count_q;
   logic [15:0] interval_q;
   logic [15:0] smp_cnt_q;
   logic [5:0] idx_q;
   logic [5:0] pend_idx_q;
   logic [7:0] first_q;
   logic [7:0] hi_q;
   logic [7:0] lo_q;
   logic [`ADM_SUM_W-1:0] sum_q;
   logic [7:0] acq_cnt_q;
   logic point_valid_q;
   logic [5:0] point_index_q;
   logic [14:0] point_data_q;
   logic seq_done_q;
   logic setup_live_q;
   logic point_live_q;

   logic div_busy;
   logic div_done;
   logic [`ADM_DIV_W-1:0] div_quot;
   logic [7:0] st_ext;
   logic [`ADM_ACC_W-1:0] st_sum;

   // Mode decode; the selected mode itself is never altered.
   wire logic tb_fast = !ext_clk_en_i && (tb_ns_per_div_i < `ADM_TB_LIMIT_NS);
   wire logic peak_fb = (mode_q == ADM_PEAK) && (tb_fast || needs_interp_i);
   wire logic hires_fb = (mode_q == ADM_HIRES) && needs_interp_i;
   wire adm_mode_e eff_mode = (peak_fb || hires_fb) ? ADM_SAMPLE : mode_q;
   wire logic multi_acq = (mode_q == ADM_ENV) || (mode_q == ADM_AVG);
   wire logic is_hires = eff_mode == ADM_HIRES;
   wire logic is_avg = eff_mode == ADM_AVG;
   wire logic is_env = eff_mode == ADM_ENV;

   // The external clock figure assumes the source never runs above its setting.
   wire logic [3:0] res_int = adm_res_bits(tb_ns_per_div_i, `ADM_TB_LIMIT_NS);
   wire logic [3:0] res_ext = adm_res_bits(`ADM_EXT_REF_HZ, external_clock_setting_i);
   wire logic [3:0] res_raw = ext_clk_en_i ? res_ext : res_int;
   wire logic [3:0] res_bits = (res_raw > `ADM_RES_MAX) ? `ADM_RES_MAX : res_raw;
   wire logic [3:0] res_shift = is_hires ? res_bits - `ADM_RES_BASE : 4'h0;

   wire logic cfg_change = (mode_i != mode_q) || (acq_count_i != count_q);
   wire logic [7:0] target = (multi_acq && acq_count_i != 8'h00) ? count_q : 8'h01;
   wire logic [6:0] pts_clamp = (record_points_i > 7'h40) ? 7'h40 : record_points_i;
   wire logic [5:0] pts_last = (pts_clamp == 7'h00) ? 6'h00 : 6'(pts_clamp - 7'h01);

   // Per-interval running values, including the sample of this cycle.
   wire logic smp_first = smp_cnt_q == 16'h0000;
   wire logic in_acq = (state_q == ADM_S_ACQ) && sample_valid_i;
   wire logic [7:0] first_n = smp_first ? sample_i : first_q;
   wire logic [7:0] hi_n = smp_first ? sample_i : adm_max8(hi_q, sample_i);
   wire logic [7:0] lo_n = smp_first ? sample_i : adm_min8(lo_q, sample_i);
   wire logic [`ADM_SUM_W-1:0] sum_n = smp_first ? {16'h0000, sample_i} : sum_q + {16'h0000, sample_i};
   wire logic [7:0] peak_val = idx_q[0] ? lo_n : hi_n;
   wire logic int_end = in_acq && (smp_cnt_q == interval_q - 16'h0001);
   wire logic rec_end = int_end && (idx_q == pts_last);

   wire logic st_upd = int_end && (is_env || is_avg);
   wire logic [7:0] st_val = is_env ? peak_val : first_n;

   // Divider serves interval setup, interval means and record averages in turn.
   wire logic setup_go = (state_q == ADM_S_IDLE) && start_i && !cfg_change;
   // A setup refused by a divider still busy from an aborted record is retried until taken.
   wire logic setup_div = setup_go || ((state_q == ADM_S_SETUP) && !setup_live_q);
   wire logic point_div = int_end && (is_hires || is_avg);
   wire logic div_start = setup_div || point_div;
   wire logic div_take = div_start && !div_busy && !cfg_change;
   wire logic [31:0] hires_num = {8'h00, sum_n} << res_shift;
   wire logic [31:0] div_num = setup_div ? {16'h0000, record_span_i} : is_hires ? hires_num : {16'h0000, st_sum};
   wire logic [31:0] div_den = setup_div ? {25'h0, pts_clamp} : is_hires ? {16'h0000, interval_q}
                               : {24'h000000, acq_cnt_q + 8'h01};

   wire logic [7:0] direct_val = is_env ? st_ext : (eff_mode == ADM_PEAK) ? peak_val : first_n;
   wire logic direct_emit = int_end && !is_hires && !is_avg;
   wire logic point_from_div = div_done && point_live_q;
   wire logic [14:0] div_point = (div_quot[31:15] != 17'h0) ? 15'h7fff : div_quot[14:0];
   wire logic [15:0] new_interval = (div_quot[31:16] != 16'h0) ? 16'hffff
                                    : (div_quot[15:0] == 16'h0) ? 16'h0001 : div_quot[15:0];

   adm_divider u_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .start_i(div_start),
      .num_i(div_num),
      .den_i(div_den),
      .busy_o(div_busy),
      .done_o(div_done),
      .quot_o(div_quot)
   );

   adm_point_store u_store (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .clr_i(cfg_change || setup_go),
      .upd_i(st_upd),
      .first_i(acq_cnt_q == 8'h00),
      .keep_max_i(!idx_q[0]),
      .idx_i(idx_q),
      .val_i(st_val),
      .ext_o(st_ext),
      .sum_o(st_sum)
   );

   // Configuration tracking; reset leaves the block in sample mode.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_q <= ADM_SAMPLE;
         count_q <= 8'h00;
      end else if (clk_en_i) begin
         mode_q <= mode_i;
         count_q <= acq_count_i;
      end
   end

   // Sequencer.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= ADM_S_IDLE;
         interval_q <= 16'h0001;
         acq_cnt_q <= 8'h00;
         seq_done_q <= 1'b0;
      end else if (clk_en_i) begin
         seq_done_q <= 1'b0;
         if (cfg_change) begin
            state_q <= ADM_S_IDLE;
            acq_cnt_q <= 8'h00;
         end else begin
            unique case (state_q)
               ADM_S_IDLE: begin
                  if (setup_go) begin
                     state_q <= ADM_S_SETUP;
                     acq_cnt_q <= 8'h00;
                  end
               end
               ADM_S_SETUP: begin
                  if (div_done && setup_live_q) begin
                     interval_q <= new_interval;
                     state_q <= ADM_S_ARM;
                  end
               end
               ADM_S_ARM: begin
                  if (trigger_i) begin
                     state_q <= ADM_S_ACQ;
                  end
               end
               ADM_S_ACQ: begin
                  if (rec_end) begin
                     state_q <= ADM_S_DRAIN;
                  end
               end
               ADM_S_DRAIN: begin
                  if (!div_busy) begin
                     acq_cnt_q <= acq_cnt_q + 8'h01;
                     if (acq_cnt_q + 8'h01 >= target) begin
                        state_q <= ADM_S_IDLE;
                        seq_done_q <= 1'b1;
                     end else begin
                        state_q <= ADM_S_ARM;
                     end
                  end
               end
               default: state_q <= ADM_S_IDLE;
            endcase
         end
      end
   end

   // Interval accumulation; a new record always starts at point zero.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         smp_cnt_q <= 16'h0000;
         idx_q <= 6'h00;
         first_q <= 8'h00;
         hi_q <= 8'h00;
         lo_q <= 8'h00;
         sum_q <= '0;
      end else if (clk_en_i) begin
         if (state_q != ADM_S_ACQ) begin
            smp_cnt_q <= 16'h0000;
            idx_q <= 6'h00;
         end else if (in_acq) begin
            first_q <= first_n;
            hi_q <= hi_n;
            lo_q <= lo_n;
            sum_q <= sum_n;
            if (int_end) begin
               smp_cnt_q <= 16'h0000;
               idx_q <= idx_q + 6'h01;
            end else begin
               smp_cnt_q <= smp_cnt_q + 16'h0001;
            end
         end
      end
   end

   // Ownership of the running divide; a result nobody owns is dropped, and a new take beats the clear.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         setup_live_q <= 1'b0;
         point_live_q <= 1'b0;
         pend_idx_q <= 6'h00;
      end else if (clk_en_i) begin
         if (div_take) begin
            setup_live_q <= setup_div;
            point_live_q <= point_div;
            pend_idx_q <= idx_q;
         end else if (cfg_change || div_done) begin
            setup_live_q <= 1'b0;
            point_live_q <= 1'b0;
         end
      end
   end

   // Point output; divided results carry the index saved when they started.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         point_valid_q <= 1'b0;
         point_index_q <= 6'h00;
         point_data_q <= 15'h0000;
      end else if (clk_en_i) begin
         point_valid_q <= direct_emit || point_from_div;
         if (direct_emit) begin
            point_index_q <= idx_q;
            point_data_q <= {7'h00, direct_val};
         end else if (point_from_div) begin
            point_index_q <= pend_idx_q;
            point_data_q <= div_point;
         end
      end
   end

   assign point_valid_o = point_valid_q;
   assign point_index_o = point_index_q;
   assign point_data_o = point_data_q;
   assign seq_done_o = seq_done_q;
   assign busy_o = state_q != ADM_S_IDLE;
   assign acq_done_count_o = acq_cnt_q;
   assign eff_mode_o = eff_mode;
   assign res_bits_o = is_hires ? res_bits : `ADM_RES_BASE;
   assign scroll_inhibit_o = multi_acq;
endmodule : adm_acq_decimator

// ===== verilog/adm_divider.sv
`timescale 1ns/100ps
`include "adm_params.svh"

module adm_divider (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic start_i,
   input wire logic [`ADM_DIV_W-1:0] num_i,
   input wire logic [`ADM_DIV_W-1:0] den_i,
   output logic busy_o,
   output logic done_o,
   output logic [`ADM_DIV_W-1:0] quot_o
);
   import adm_pkg::*;

   logic [`ADM_DIV_W:0] rem_q;
   logic [`ADM_DIV_W-1:0] quo_q;
   logic [`ADM_DIV_W-1:0] den_q;
   logic [5:0] cnt_q;
   logic busy_q;
   logic done_q;
   wire logic [`ADM_DIV_W:0] rem_shift = {rem_q[`ADM_DIV_W-1:0], quo_q[`ADM_DIV_W-1]};
   wire logic fits = rem_shift >= {1'b0, den_q};

   // A zero divisor yields all ones, which callers treat as saturation.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rem_q <= '0;
         quo_q <= '0;
         den_q <= '0;
         cnt_q <= 6'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else if (clk_en_i) begin
         done_q <= 1'b0;
         if (start_i && !busy_q) begin
            rem_q <= '0;
            quo_q <= num_i;
            den_q <= den_i;
            cnt_q <= 6'h00;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            rem_q <= fits ? rem_shift - {1'b0, den_q} : rem_shift;
            quo_q <= {quo_q[`ADM_DIV_W-2:0], fits};
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == `ADM_DIV_STEPS) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

   assign busy_o = busy_q;
   assign done_o = done_q;
   assign quot_o = quo_q;
endmodule : adm_divider

// ===== verilog/adm_params.svh
`ifndef ADM_PARAMS_SVH
`define ADM_PARAMS_SVH

`define ADM_CLK_PERIOD_NS 50
`define ADM_REC_POINTS 64
`define ADM_IDX_W 6
`define ADM_SMP_W 8
`define ADM_SUM_W 24
`define ADM_ACC_W 16
`define ADM_DIV_W 32
`define ADM_DIV_STEPS 6'h1f
`define ADM_RES_BASE 4'h8
`define ADM_RES_MAX 4'hf
`define ADM_RES_DOUBLINGS 14
// Time base from which resolution doublings are counted, in ns per division.
`define ADM_TB_LIMIT_NS 32'h000001f4
// Reference rate for the external clock resolution figure, in Hz.
`define ADM_EXT_REF_HZ 32'h05f5e100
`define ADM_MODE_RST 3'h0

`endif

// ===== verilog/adm_pkg.sv
package adm_pkg;

   typedef enum logic [2:0] {
      ADM_SAMPLE = 3'h0,
      ADM_PEAK = 3'h1,
      ADM_HIRES = 3'h2,
      ADM_ENV = 3'h3,
      ADM_AVG = 3'h4
   } adm_mode_e;

   typedef enum logic [2:0] {
      ADM_S_IDLE = 3'h0,
      ADM_S_SETUP = 3'h1,
      ADM_S_ARM = 3'h3,
      ADM_S_ACQ = 3'h2,
      ADM_S_DRAIN = 3'h6
   } adm_state_e;

   function automatic logic [7:0] adm_max8(input logic [7:0] a, input logic [7:0] b);
      adm_max8 = (a > b) ? a : b;
   endfunction : adm_max8

   function automatic logic [7:0] adm_min8(input logic [7:0] a, input logic [7:0] b);
      adm_min8 = (a < b) ? a : b;
   endfunction : adm_min8

endpackage : adm_pkg

// ===== verilog/adm_point_store.sv
`timescale 1ns/100ps
`include "adm_params.svh"

module adm_point_store (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic clr_i,
   input wire logic upd_i,
   input wire logic first_i,
   input wire logic keep_max_i,
   input wire logic [`ADM_IDX_W-1:0] idx_i,
   input wire logic [`ADM_SMP_W-1:0] val_i,
   output logic [`ADM_SMP_W-1:0] ext_o,
   output logic [`ADM_ACC_W-1:0] sum_o
);
   import adm_pkg::*;

   logic [`ADM_SMP_W-1:0] ext_q [`ADM_REC_POINTS];
   logic [`ADM_ACC_W-1:0] sum_q [`ADM_REC_POINTS];
   wire logic [`ADM_SMP_W-1:0] old_ext = ext_q[idx_i];
   wire logic [`ADM_SMP_W-1:0] kept = keep_max_i ? adm_max8(old_ext, val_i) : adm_min8(old_ext, val_i);

   // The first acquisition overwrites, so stale data can never leak in.
   assign ext_o = first_i ? val_i : kept;
   assign sum_o = first_i ? {8'h00, val_i} : sum_q[idx_i] + {8'h00, val_i};

   always_ff @(posedge clk_i) begin
      if (reset_i || (clk_en_i && clr_i)) begin
         for (int i = 0; i < `ADM_REC_POINTS; i++) begin
            ext_q[i] <= '0;
            sum_q[i] <= '0;
         end
      end else if (clk_en_i && upd_i) begin
         ext_q[idx_i] <= ext_o;
         sum_q[idx_i] <= sum_o;
      end
   end
endmodule : adm_point_store
